// [hdl/rpc_cache_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module rpc_cache_ctrl
   import rpc_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic LINK_FUNDAMENTAL_RESET,
   input wire logic GLOBAL_CHIP_RESET,
   input wire logic HOT_RESET,
   input wire logic [7:0] CFG_ADDR,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [15:0] CFG_WDATA,
   output logic [15:0] CFG_RDATA,
   output logic CFG_RVALID,
   input wire logic CPL_LOAD,
   input wire logic PCI_CYCLE_START,
   input wire logic READ_HIT,
   input wire logic DATA_DELIVERED,
   input wire logic XFER_END,
   input wire logic XFER_END_RETRY,
   output logic PREFETCH_ENABLE,
   output logic AUTO_PREFETCH_ENABLE,
   output logic SINGLE_BUFFER,
   output logic [3:0] PREFETCH_BURST_COUNT,
   output logic [13:0] PREFETCH_BYTE_LENGTH,
   output logic CACHE_VALID,
   output logic CACHE_DISCARD
);
   // ----------------------------------------
   // configuration fields
   // ----------------------------------------
   logic [1:0] completion_cache_policy_r;
   logic [3:0] prefetch_burst_count_r;
   logic [3:0] prefetch_byte_length_r;
   logic [7:0] idle_cycle_start_limit_r;
   logic [11:0] min_clk_limit_r;
   logic [11:0] max_clk_limit_r;
   logic field_rst;
   logic [15:0] rdata_nxt;

   assign field_rst = LINK_FUNDAMENTAL_RESET | GLOBAL_CHIP_RESET;

   // prefetch agent limits register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         completion_cache_policy_r <= POLICY_RST;
         prefetch_burst_count_r <= BURST_RST;
         prefetch_byte_length_r <= LENGTH_RST;
      end else if (field_rst) begin
         completion_cache_policy_r <= POLICY_RST;
         prefetch_burst_count_r <= BURST_RST;
         prefetch_byte_length_r <= LENGTH_RST;
      end else if (CFG_WR && (CFG_ADDR == PFA_LIMITS_OFS)) begin
         completion_cache_policy_r <= CFG_WDATA[POLICY_LSB +: POLICY_W];
         prefetch_burst_count_r <= CFG_WDATA[BURST_LSB +: BURST_W];
         prefetch_byte_length_r <= CFG_WDATA[LENGTH_LSB +: LENGTH_W];
      end
   end

   // cycle start limit register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         idle_cycle_start_limit_r <= CYC_LIMIT_RST;
      end else if (field_rst) begin
         idle_cycle_start_limit_r <= CYC_LIMIT_RST;
      end else if (CFG_WR && (CFG_ADDR == CYC_LIMIT_OFS)) begin
         idle_cycle_start_limit_r <= CFG_WDATA[CYC_LIMIT_W-1:0];
      end
   end

   // minimum clock limit register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         min_clk_limit_r <= MIN_CLK_LIMIT_RST;
      end else if (field_rst) begin
         min_clk_limit_r <= MIN_CLK_LIMIT_RST;
      end else if (CFG_WR && (CFG_ADDR == MIN_CLK_LIMIT_OFS)) begin
         min_clk_limit_r <= CFG_WDATA[CLK_LIMIT_W-1:0];
      end
   end

   // discard clock limit register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         max_clk_limit_r <= MAX_CLK_LIMIT_RST;
      end else if (field_rst) begin
         max_clk_limit_r <= MAX_CLK_LIMIT_RST;
      end else if (CFG_WR && (CFG_ADDR == MAX_CLK_LIMIT_OFS)) begin
         max_clk_limit_r <= CFG_WDATA[CLK_LIMIT_W-1:0];
      end
   end

   // ----------------------------------------
   // register read
   // ----------------------------------------
   always_comb begin
      rdata_nxt = 16'h0000;
      case (CFG_ADDR)
         PFA_LIMITS_OFS: begin
            rdata_nxt[POLICY_LSB +: POLICY_W] = completion_cache_policy_r;
            rdata_nxt[BURST_LSB +: BURST_W] = prefetch_burst_count_r;
            rdata_nxt[LENGTH_LSB +: LENGTH_W] = prefetch_byte_length_r;
         end
         CYC_LIMIT_OFS: rdata_nxt = {8'h00, idle_cycle_start_limit_r};
         MIN_CLK_LIMIT_OFS: rdata_nxt = {4'h0, min_clk_limit_r};
         MAX_CLK_LIMIT_OFS: rdata_nxt = {4'h0, max_clk_limit_r};
         default: rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         CFG_RDATA <= 16'h0000;
         CFG_RVALID <= 1'b0;
      end else begin
         CFG_RVALID <= CFG_RD;
         if (CFG_RD) begin
            CFG_RDATA <= rdata_nxt;
         end
      end
   end

   // ----------------------------------------
   // prefetch agent controls
   // ----------------------------------------
   // codes above seven saturate at the largest size
   function automatic logic [BYTES_W-1:0] length_bytes(input logic [3:0] code);
      if (code > 4'h7) begin
         return BASE_BYTES << 4'h7;
      end
      return BASE_BYTES << code;
   endfunction : length_bytes

   // ----------------------------------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         PREFETCH_ENABLE <= 1'b0;
         AUTO_PREFETCH_ENABLE <= 1'b0;
         SINGLE_BUFFER <= 1'b0;
         PREFETCH_BURST_COUNT <= 4'h0;
         PREFETCH_BYTE_LENGTH <= BASE_BYTES;
      end else begin
         PREFETCH_ENABLE <= (completion_cache_policy_r == POLICY_LIGHT) ||
                            (completion_cache_policy_r == POLICY_FULL);
         AUTO_PREFETCH_ENABLE <= (prefetch_burst_count_r != BURST_OFF) &&
                                 (prefetch_burst_count_r != BURST_ONE_BUFFER);
         SINGLE_BUFFER <= (prefetch_burst_count_r == BURST_ONE_BUFFER);
         PREFETCH_BURST_COUNT <= prefetch_burst_count_r;
         PREFETCH_BYTE_LENGTH <= length_bytes(prefetch_byte_length_r);
      end
   end

   // ----------------------------------------
   // discard decision
   // ----------------------------------------
   logic [7:0] cyc_cnt_r;
   logic [11:0] clk_cnt_r;
   logic xfer_drop;
   logic timer_drop;
   logic discard_nxt;

   always_comb begin
      xfer_drop = 1'b0;
      case (completion_cache_policy_r)
         POLICY_NONE: xfer_drop = DATA_DELIVERED;
         POLICY_LIGHT: xfer_drop = XFER_END && !XFER_END_RETRY;
         POLICY_FULL: xfer_drop = 1'b0;
         default: xfer_drop = DATA_DELIVERED;
      endcase
   end

   assign timer_drop = ((cyc_cnt_r >= idle_cycle_start_limit_r) &&
                        (clk_cnt_r >= min_clk_limit_r)) ||
                       (clk_cnt_r >= max_clk_limit_r);
   assign discard_nxt = CACHE_VALID && !READ_HIT && !CPL_LOAD && (xfer_drop || timer_drop);

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         CACHE_DISCARD <= 1'b0;
      end else begin
         CACHE_DISCARD <= discard_nxt;
      end
   end

   // a new load wins over a discard decided in the same cycle
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         CACHE_VALID <= 1'b0;
      end else if (HOT_RESET || field_rst) begin
         CACHE_VALID <= 1'b0;
      end else if (CPL_LOAD) begin
         CACHE_VALID <= 1'b1;
      end else if (discard_nxt) begin
         CACHE_VALID <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cyc_cnt_r <= 8'h00;
         clk_cnt_r <= 12'h000;
      end else if (!CACHE_VALID || READ_HIT || CPL_LOAD || discard_nxt || HOT_RESET) begin
         cyc_cnt_r <= 8'h00;
         clk_cnt_r <= 12'h000;
      end else begin
         if (PCI_CYCLE_START && cyc_cnt_r != 8'hFF) begin
            cyc_cnt_r <= cyc_cnt_r + 8'h01;
         end
         if (clk_cnt_r != 12'hFFF) begin
            clk_cnt_r <= clk_cnt_r + 12'h001;
         end
      end
   end
endmodule : rpc_cache_ctrl
`default_nettype wire

// [hdl/rpc_pkg.sv]
package rpc_pkg;
   // ----------------------------------------
   // register offsets in configuration space
   // ----------------------------------------
   localparam logic [7:0] PFA_LIMITS_OFS = 8'hE8;
   localparam logic [7:0] CYC_LIMIT_OFS = 8'hEA;
   localparam logic [7:0] MIN_CLK_LIMIT_OFS = 8'hEC;
   localparam logic [7:0] MAX_CLK_LIMIT_OFS = 8'hEE;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int POLICY_LSB = 6;
   localparam int POLICY_W = 2;
   localparam int BURST_LSB = 8;
   localparam int BURST_W = 4;
   localparam int LENGTH_LSB = 0;
   localparam int LENGTH_W = 4;
   localparam int CYC_LIMIT_W = 8;
   localparam int CLK_LIMIT_W = 12;
   localparam int BYTES_W = 14;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [1:0] POLICY_RST = 2'h1;
   localparam logic [3:0] BURST_RST = 4'h4;
   localparam logic [3:0] LENGTH_RST = 4'h3;
   localparam logic [7:0] CYC_LIMIT_RST = 8'h08;
   localparam logic [11:0] MIN_CLK_LIMIT_RST = 12'h07F;
   localparam logic [11:0] MAX_CLK_LIMIT_RST = 12'h1C0;
   // ----------------------------------------
   // encodings
   // ----------------------------------------
   localparam logic [1:0] POLICY_NONE = 2'h0;
   localparam logic [1:0] POLICY_LIGHT = 2'h1;
   localparam logic [1:0] POLICY_FULL = 2'h2;
   localparam logic [3:0] BURST_OFF = 4'h0;
   localparam logic [3:0] BURST_ONE_BUFFER = 4'h1;
   localparam logic [BYTES_W-1:0] BASE_BYTES = 14'h0040;
endpackage : rpc_pkg

// [tb/rpc_cache_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module rpc_cache_ctrl_chk
   import rpc_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic LINK_FUNDAMENTAL_RESET,
   input wire logic GLOBAL_CHIP_RESET,
   input wire logic HOT_RESET,
   input wire logic CFG_RD,
   input wire logic [7:0] CFG_ADDR,
   input wire logic [15:0] CFG_RDATA,
   input wire logic CFG_RVALID,
   input wire logic CPL_LOAD,
   input wire logic READ_HIT,
   input wire logic CACHE_VALID,
   input wire logic CACHE_DISCARD,
   input wire logic AUTO_PREFETCH_ENABLE,
   input wire logic SINGLE_BUFFER,
   input wire logic [3:0] PREFETCH_BURST_COUNT,
   input wire logic [13:0] PREFETCH_BYTE_LENGTH
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   // ----
   // checks
   // ----
   logic clr_any;
   assign clr_any = LINK_FUNDAMENTAL_RESET | GLOBAL_CHIP_RESET | HOT_RESET;
   rd_answer_a:
      assert property (CFG_RD |=> CFG_RVALID) else $error("no read answer");
   pfa_rsvd_a:
      assert property (CFG_RD && CFG_ADDR == PFA_LIMITS_OFS |=> CFG_RDATA[5:4] == 2'h0)
      else $error("limits reserved bits");
   cyc_rsvd_a:
      assert property (CFG_RD && CFG_ADDR == CYC_LIMIT_OFS |=> CFG_RDATA[15:8] == 8'h00)
      else $error("cycle limit upper byte");
   clk_rsvd_a:
      assert property (CFG_RD && CFG_ADDR == MIN_CLK_LIMIT_OFS |=> CFG_RDATA[15:12] == 4'h0)
      else $error("clock limit upper bits");
   len_pow_a:
      assert property ($onehot(PREFETCH_BYTE_LENGTH) && PREFETCH_BYTE_LENGTH >= 14'h0040)
      else $error("byte length");
   burst_mode_a:
      assert property (SINGLE_BUFFER == (PREFETCH_BURST_COUNT == 4'h1)
         && AUTO_PREFETCH_ENABLE == (PREFETCH_BURST_COUNT > 4'h1)) else $error("burst mode");
   discard_pulse_a:
      assert property (CACHE_DISCARD |-> !CACHE_VALID ##1 !CACHE_DISCARD) else $error("discard");
   load_valid_a:
      assert property (CPL_LOAD && !clr_any |=> CACHE_VALID && !CACHE_DISCARD)
      else $error("load");
   hit_keep_a:
      assert property (READ_HIT && CACHE_VALID && !clr_any |=> CACHE_VALID && !CACHE_DISCARD)
      else $error("hit");
   cover property (CACHE_DISCARD);
   cover property (READ_HIT && CACHE_VALID);
   cover property (SINGLE_BUFFER);
endmodule : rpc_cache_ctrl_chk
bind rpc_cache_ctrl rpc_cache_ctrl_chk rpc_cache_ctrl_chk_inst (.CLK(CLK), .NRST(NRST),
   .LINK_FUNDAMENTAL_RESET(LINK_FUNDAMENTAL_RESET), .GLOBAL_CHIP_RESET(GLOBAL_CHIP_RESET),
   .HOT_RESET(HOT_RESET), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_RDATA(CFG_RDATA),
   .CFG_RVALID(CFG_RVALID), .CPL_LOAD(CPL_LOAD), .READ_HIT(READ_HIT), .CACHE_VALID(CACHE_VALID),
   .CACHE_DISCARD(CACHE_DISCARD), .AUTO_PREFETCH_ENABLE(AUTO_PREFETCH_ENABLE),
   .SINGLE_BUFFER(SINGLE_BUFFER), .PREFETCH_BURST_COUNT(PREFETCH_BURST_COUNT),
   .PREFETCH_BYTE_LENGTH(PREFETCH_BYTE_LENGTH));
`default_nettype wire

// [tb/rpc_cache_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rpc_cache_ctrl_tb;
   import rpc_pkg::*;
   logic clk, nrst, lfr, gcr, hot, wr, rd, load, pf, apf, sb, vld, cs, hit, dlv, xe, rty;
   logic [7:0] addr;
   logic [15:0] wd, rdat;
   logic [3:0] bc;
   logic [13:0] len;
   int n_fail = 0, n_tests = 0, cyc = 0;
   rpc_cache_ctrl rpc_cache_ctrl_inst (.CLK(clk), .NRST(nrst), .LINK_FUNDAMENTAL_RESET(lfr),
      .GLOBAL_CHIP_RESET(gcr), .HOT_RESET(hot), .CFG_ADDR(addr), .CFG_WR(wr), .CFG_RD(rd),
      .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_RVALID(), .CPL_LOAD(load), .PCI_CYCLE_START(cs),
      .READ_HIT(hit), .DATA_DELIVERED(dlv), .XFER_END(xe), .XFER_END_RETRY(rty),
      .PREFETCH_ENABLE(pf), .AUTO_PREFETCH_ENABLE(apf), .SINGLE_BUFFER(sb),
      .PREFETCH_BURST_COUNT(bc), .PREFETCH_BYTE_LENGTH(len), .CACHE_VALID(vld), .CACHE_DISCARD());
   rpc_pci_master rpc_pci_master_inst (.clk(clk), .cyc_start(cs), .hit(hit), .delivered(dlv),
      .xfer_end(xe), .retry(rty));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----
   // tasks
   // ----
   task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask : cmp
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk) {addr, wd, wr} = {a, d, 1'b1};
      @(negedge clk) wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk) {addr, rd} = {a, 1'b1};
      @(negedge clk) rd = 1'b0;
      cmp("rdata", e, rdat);
   endtask : rd_reg
   task automatic strobe(ref logic s, input int gap);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
      repeat (gap) @(negedge clk);
   endtask : strobe
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   // ----
   // tests
   // ----
   initial begin
      {nrst, lfr, gcr, hot, wr, rd, load, addr, wd} = '0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      rd_reg(PFA_LIMITS_OFS, 16'h0443);
      rd_reg(CYC_LIMIT_OFS, 16'h0008);
      rd_reg(MIN_CLK_LIMIT_OFS, 16'h007F);
      rd_reg(MAX_CLK_LIMIT_OFS, 16'h01C0);
      rd_reg(8'hE0, 16'h0000);
      wr_reg(PFA_LIMITS_OFS, 16'hFFFF);
      rd_reg(PFA_LIMITS_OFS, 16'h0FCF);
      wr_reg(CYC_LIMIT_OFS, 16'hFFFF);
      rd_reg(CYC_LIMIT_OFS, 16'h00FF);
      wr_reg(MIN_CLK_LIMIT_OFS, 16'hFFFF);
      rd_reg(MIN_CLK_LIMIT_OFS, 16'h0FFF);
      strobe(hot, 0);
      rd_reg(CYC_LIMIT_OFS, 16'h00FF);
      rd_reg(PFA_LIMITS_OFS, 16'h0FCF);
      strobe(lfr, 0);
      rd_reg(CYC_LIMIT_OFS, 16'h0008);
      rd_reg(PFA_LIMITS_OFS, 16'h0443);
      wr_reg(MIN_CLK_LIMIT_OFS, 16'hFFFF);
      strobe(gcr, 0);
      rd_reg(MIN_CLK_LIMIT_OFS, 16'h007F);
      $display("registers done");
      for (int c = 0; c < 8; c++) begin
         wr_reg(PFA_LIMITS_OFS, {4'h0, 4'(c), 4'h0, 4'(c)});
         @(negedge clk);
         cmp("length", 16'h0040 << c, {2'h0, len});
         cmp("burst", {8'h0, 4'(c), 2'h0, c > 1, c == 1}, {8'h0, bc, 2'h0, apf, sb});
      end
      $display("prefetch fields done");
      for (int p = 0; p < 6; p++) begin
         wr_reg(PFA_LIMITS_OFS, {4'h0, 4'h4, 2'(p / 2), 2'h0, 4'h3});
         strobe(load, 0);
         cmp("prefetch", {15'h0, p > 1}, {15'h0, pf});
         rpc_pci_master_inst.xfer(p[0], p);
         @(negedge clk);
         cmp("kept", {15'h0, p >= 3}, {15'h0, vld});
      end
      $display("policies done");
      wr_reg(CYC_LIMIT_OFS, 16'h0002);
      wr_reg(MIN_CLK_LIMIT_OFS, 16'h0010);
      strobe(load, 0);
      rpc_pci_master_inst.pulse(5'h10, 0);
      rpc_pci_master_inst.pulse(5'h10, 0);
      repeat (5) @(negedge clk);
      cmp("min wait", 16'h1, {15'h0, vld});
      repeat (11) @(negedge clk);
      cmp("cycle limit", 16'h0, {15'h0, vld});
      wr_reg(CYC_LIMIT_OFS, 16'h00FF);
      wr_reg(MAX_CLK_LIMIT_OFS, 16'h0020);
      strobe(load, 20);
      rpc_pci_master_inst.pulse(5'h18, 26);
      cmp("restart", 16'h1, {15'h0, vld});
      repeat (10) @(negedge clk);
      cmp("max limit", 16'h0, {15'h0, vld});
      $display("timers done");
      stop_test();
   end
endmodule : rpc_cache_ctrl_tb
`default_nettype wire

// [tb/rpc_pci_master.sv]
`timescale 1ns/1ps
`default_nettype none
module rpc_pci_master (
   input wire logic clk,
   output logic cyc_start,
   output logic hit,
   output logic delivered,
   output logic xfer_end,
   output logic retry
);
   initial {cyc_start, hit, delivered, xfer_end, retry} = 5'h00;
   // one bus event for one cycle, then an optional wait
   task automatic pulse(input logic [4:0] v, input int gap);
      @(negedge clk) {cyc_start, hit, delivered, xfer_end, retry} = v;
      @(negedge clk) {cyc_start, hit, delivered, xfer_end, retry} = 5'h00;
      repeat (gap) @(negedge clk);
   endtask : pulse
   // start with hit, data returned, end by master or by bridge retry
   task automatic xfer(input logic rty, input int gap);
      pulse(5'h18, 0);
      pulse(5'h04, gap);
      pulse({4'h1, rty}, 0);
   endtask : xfer
endmodule : rpc_pci_master
`default_nettype wire
